/* hdl/txrs_consts.svh */
`ifndef TXRS_CONSTS_SVH
`define TXRS_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------------------
`define TXRS_ADDR_CTRL        12'h000
`define TXRS_ADDR_CFG         12'h004
`define TXRS_ADDR_STAT        12'h008

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define TXRS_CTRL_RATE_LSB    0
`define TXRS_CTRL_RATE_MSB    1
`define TXRS_CTRL_MUX_BIT     2
`define TXRS_CTRL_INV_BIT     3
`define TXRS_CTRL_RST         4'h0
`define TXRS_CFG_CLKOUT_BIT   0
`define TXRS_CFG_SYNCOUT_BIT  1
`define TXRS_CFG_RST          2'h0
`define TXRS_STAT_BYTE_LSB    0
`define TXRS_STAT_SLOT_LSB    8
`define TXRS_STAT_FRAME_LSB   16
`define TXRS_STAT_MODE_LSB    24

// ----------------------------------------------------------------------------
// Rate select codes
// ----------------------------------------------------------------------------
`define TXRS_RATE_BASE        2'h0
`define TXRS_RATE_MVIP        2'h1
`define TXRS_RATE_HS4         2'h2
`define TXRS_RATE_HS8         2'h3

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define TXRS_REF_KHZ          50000
`define TXRS_BASE_KHZ         2048
`define TXRS_FRAME_US         125
`define TXRS_MFRAME_US        2000
`define TXRS_BITS_PER_FRAME   (`TXRS_FRAME_US * `TXRS_BASE_KHZ / 1000)
`define TXRS_FRAMES_PER_MF    (`TXRS_MFRAME_US / `TXRS_FRAME_US)
`define TXRS_CLKGEN_STEP      (2 * `TXRS_BASE_KHZ)
`define TXRS_CLKGEN_MOD       (`TXRS_REF_KHZ)

`endif

/* hdl/txrs_pkg.sv */
package txrs_pkg;

	typedef enum logic [2:0] {
		TXRS_MODE_BASE,
		TXRS_MODE_MVIP,
		TXRS_MODE_HS4,
		TXRS_MODE_HS8,
		TXRS_MODE_MUX
	} txrs_mode_t;

endpackage

/* hdl/txrs_reg_if.sv */
`timescale 1ns/1ps

interface txrs_reg_if;
	logic [1:0]  rate_sel;
	logic        mux_en;
	logic        clk_inv;
	logic        clk_out_en;
	logic        sync_out_en;
	logic [31:0] status;

	modport regs (
		output rate_sel,
		output mux_en,
		output clk_inv,
		output clk_out_en,
		output sync_out_en,
		input  status
	);

	modport core (
		input  rate_sel,
		input  mux_en,
		input  clk_inv,
		input  clk_out_en,
		input  sync_out_en,
		output status
	);
endinterface

/* hdl/txrs_ahb_regs.sv */
`timescale 1ns/1ps
`include "txrs_consts.svh"

module txrs_ahb_regs (
	input  logic        ref_clk,
	input  logic        reset,
	input  logic        hsel,
	input  logic [31:0] haddr,
	input  logic [1:0]  htrans,
	input  logic        hwrite,
	input  logic [2:0]  hsize,
	input  logic [31:0] hwdata,
	input  logic        hready,
	output logic        hreadyout,
	output logic        hresp,
	output logic [31:0] hrdata,
	txrs_reg_if.regs    rif
);

	// ------------------------------------------------------------------------
	// Address phase capture
	// ------------------------------------------------------------------------
	logic [11:0] dp_addr;
	logic        dp_write;
	logic [3:0]  ctrl;
	logic [1:0]  cfg;

	wire         ap_valid   = hsel && hready && htrans[1];
	wire         wr_ctrl    = dp_write && (dp_addr == `TXRS_ADDR_CTRL);
	wire         wr_cfg     = dp_write && (dp_addr == `TXRS_ADDR_CFG);
	wire [3:0]   next_ctrl  = wr_ctrl ? hwdata[3:0] : ctrl;
	wire [1:0]   next_cfg   = wr_cfg ? hwdata[1:0] : cfg;
	wire [11:0]  ap_addr    = haddr[11:0];

	// Reads use the next values so a read right behind a write sees it.
	wire [31:0]  rd_value   = (ap_addr == `TXRS_ADDR_CTRL) ? {28'h000_0000, next_ctrl} :
	                          (ap_addr == `TXRS_ADDR_CFG)  ? {30'h0000_0000, next_cfg} :
	                          (ap_addr == `TXRS_ADDR_STAT) ? rif.status :
	                          32'h0000_0000;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			dp_write <= 1'b0;
			dp_addr  <= 12'h000;
			hrdata   <= 32'h0000_0000;
		end else begin
			dp_write <= ap_valid && hwrite && (hsize == 3'h2);
			dp_addr  <= ap_addr;
			if (ap_valid && !hwrite) begin
				hrdata <= rd_value;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ctrl <= `TXRS_CTRL_RST;
			cfg  <= `TXRS_CFG_RST;
		end else begin
			ctrl <= next_ctrl;
			cfg  <= next_cfg;
		end
	end

	assign hreadyout       = 1'b1;
	assign hresp           = 1'b0;
	assign rif.rate_sel    = ctrl[`TXRS_CTRL_RATE_MSB:`TXRS_CTRL_RATE_LSB];
	assign rif.mux_en      = ctrl[`TXRS_CTRL_MUX_BIT];
	assign rif.clk_inv     = ctrl[`TXRS_CTRL_INV_BIT];
	assign rif.clk_out_en  = cfg[`TXRS_CFG_CLKOUT_BIT];
	assign rif.sync_out_en = cfg[`TXRS_CFG_SYNCOUT_BIT];

endmodule

/* hdl/txrs_top.sv */
// Operation
// - The two-bit rate select field sets the transmit backplane speed.
// - With multiplexed mode off, codes follow the non-multiplexed table only.
// - Code 00: base rate 2.048 Mbit/s; serial clock input or output.
// - Base rate: multiframe sync marks the superframe every 2 ms.
// - Base rate: frame sync marks each frame every 125 us.
// - Code 01: multiframe sync pin becomes 2.048 MHz high-speed data clock.
// - Code 10: 4.096 Mbit/s; multiframe sync pin is 4.096 MHz data clock.
// - Code 11: 8.192 Mbit/s; multiframe sync pin is 8.192 MHz data clock.
// - High-speed modes: frame sync still marks the single frame boundary.
// - Multiplexed enable set leaves the non-multiplexed table out of use.
`timescale 1ns/1ps
`include "txrs_consts.svh"

module txrs_top (
	input  logic        ref_clk,
	input  logic        reset,
	input  logic        hsel,
	input  logic [31:0] haddr,
	input  logic [1:0]  htrans,
	input  logic        hwrite,
	input  logic [2:0]  hsize,
	input  logic [31:0] hwdata,
	input  logic        hready,
	output logic        hreadyout,
	output logic        hresp,
	output logic [31:0] hrdata,
	input  logic        tx_serial_clock_in,
	output logic        tx_serial_clock_out,
	output logic        tx_serial_clock_oe,
	input  logic        tx_multiframe_sync_in,
	output logic        tx_multiframe_sync_out,
	output logic        tx_multiframe_sync_oe,
	input  logic        tx_frame_sync_in,
	output logic        tx_frame_sync_out,
	output logic        tx_frame_sync_oe,
	input  logic        tx_serial_data
);

	// ------------------------------------------------------------------------
	// Register slave
	// ------------------------------------------------------------------------
	txrs_reg_if rif ();

	txrs_ahb_regs u_regs (
		.ref_clk   (ref_clk),
		.reset     (reset),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.rif       (rif)
	);

	// ------------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------------
	// Stage 1 feeds only stage 2; edges are found between stages 2 and 3.
	logic [2:0] sclk_sync;
	logic [2:0] msync_sync;
	logic [2:0] fsync_sync;
	logic [1:0] sdata_sync;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sclk_sync  <= 3'h0;
			msync_sync <= 3'h0;
			fsync_sync <= 3'h0;
			sdata_sync <= 2'h0;
		end else begin
			sclk_sync  <= {sclk_sync[1:0], tx_serial_clock_in};
			msync_sync <= {msync_sync[1:0], tx_multiframe_sync_in};
			fsync_sync <= {fsync_sync[1:0], tx_frame_sync_in};
			sdata_sync <= {sdata_sync[0], tx_serial_data};
		end
	end

	wire sclk_in_rise  = sclk_sync[1] && !sclk_sync[2];
	wire sclk_in_fall  = !sclk_sync[1] && sclk_sync[2];
	wire msync_rise    = msync_sync[1] && !msync_sync[2];
	wire msync_fall    = !msync_sync[1] && msync_sync[2];
	wire fsync_rise    = fsync_sync[1] && !fsync_sync[2];
	wire data_bit      = sdata_sync[1];

	// ------------------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------------------
	txrs_pkg::txrs_mode_t mode;

	assign mode = rif.mux_en ? txrs_pkg::TXRS_MODE_MUX :
	              (rif.rate_sel == `TXRS_RATE_BASE) ? txrs_pkg::TXRS_MODE_BASE :
	              (rif.rate_sel == `TXRS_RATE_MVIP) ? txrs_pkg::TXRS_MODE_MVIP :
	              (rif.rate_sel == `TXRS_RATE_HS4)  ? txrs_pkg::TXRS_MODE_HS4 :
	              txrs_pkg::TXRS_MODE_HS8;

	wire base_mode  = (mode == txrs_pkg::TXRS_MODE_BASE);
	wire hs_mode    = (mode == txrs_pkg::TXRS_MODE_MVIP) || (mode == txrs_pkg::TXRS_MODE_HS4) ||
	                  (mode == txrs_pkg::TXRS_MODE_HS8);
	wire table_on   = base_mode || hs_mode;

	// The serial clock may only be driven at base rate.
	wire sclk_drive = base_mode && rif.clk_out_en;
	wire sync_drive = table_on && rif.sync_out_en;

	// ------------------------------------------------------------------------
	// Serial clock generator
	// ------------------------------------------------------------------------
	// 50 MHz is no integer multiple of 2.048 MHz, so a phase accumulator
	// toggles the clock; each half period jitters by one ref_clk cycle.
	logic [15:0] acc;
	logic        gen_clk;

	wire [16:0] acc_sum  = {1'b0, acc} + 17'(`TXRS_CLKGEN_STEP);
	wire        acc_wrap = (acc_sum >= 17'(`TXRS_CLKGEN_MOD));
	wire [15:0] next_acc = acc_wrap ? 16'(acc_sum - 17'(`TXRS_CLKGEN_MOD)) : acc_sum[15:0];

	always_ff @(posedge ref_clk) begin
		if (reset || !sclk_drive) begin
			acc     <= 16'h0000;
			gen_clk <= 1'b0;
		end else begin
			acc <= next_acc;
			if (acc_wrap) begin
				gen_clk <= !gen_clk;
			end
		end
	end

	wire sclk_rise = sclk_drive ? (acc_wrap && !gen_clk) : sclk_in_rise;
	wire sclk_fall = sclk_drive ? (acc_wrap && gen_clk) : sclk_in_fall;

	// ------------------------------------------------------------------------
	// Frame and multiframe timing on the 2.048 MHz serial clock
	// ------------------------------------------------------------------------
	logic [7:0] bit_cnt;
	logic [3:0] frame_cnt;
	logic       fsync_out;
	logic       msync_out;

	wire last_bit    = (bit_cnt == 8'(`TXRS_BITS_PER_FRAME - 1));
	wire last_frame  = (frame_cnt == 4'(`TXRS_FRAMES_PER_MF - 1));
	wire ext_frame   = !sync_drive && fsync_rise;
	wire ext_mframe  = !sync_drive && base_mode && msync_rise;
	wire frame_start = sync_drive ? (sclk_rise && last_bit) : ext_frame;

	always_ff @(posedge ref_clk) begin
		if (reset || !table_on) begin
			bit_cnt   <= 8'h00;
			frame_cnt <= 4'h0;
		end else begin
			if (ext_frame) begin
				bit_cnt <= 8'h00;
			end else if (sclk_rise) begin
				bit_cnt <= last_bit ? 8'h00 : bit_cnt + 8'h01;
			end
			if (ext_mframe) begin
				frame_cnt <= 4'h0;
			end else if (frame_start) begin
				frame_cnt <= last_frame ? 4'h0 : frame_cnt + 4'h1;
			end
		end
	end

	// Generated syncs are one serial bit wide, at bit 0 of the frame.
	always_ff @(posedge ref_clk) begin
		if (reset || !sync_drive) begin
			fsync_out <= 1'b0;
			msync_out <= 1'b0;
		end else if (sclk_rise) begin
			fsync_out <= last_bit;
			msync_out <= last_bit && last_frame;
		end
	end

	// ------------------------------------------------------------------------
	// Data capture
	// ------------------------------------------------------------------------
	// Data changes on the rising edge unless inverted, so it is sampled on
	// the opposite edge; inversion applies at base rate only.
	wire dclk_rise = hs_mode ? msync_rise : sclk_rise;
	wire dclk_fall = hs_mode ? msync_fall : sclk_fall;
	wire sample_en = table_on && ((base_mode && rif.clk_inv) ? dclk_rise : dclk_fall);

	logic [9:0] data_cnt;
	logic [6:0] shift;
	logic [7:0] last_byte;
	logic [6:0] last_slot;

	always_ff @(posedge ref_clk) begin
		if (reset || !table_on) begin
			data_cnt  <= 10'h000;
			shift     <= 7'h00;
			last_byte <= 8'h00;
			last_slot <= 7'h00;
		end else if (frame_start) begin
			data_cnt <= 10'h000;
		end else if (sample_en) begin
			data_cnt <= data_cnt + 10'h001;
			shift    <= {shift[5:0], data_bit};
			if (data_cnt[2:0] == 3'h7) begin
				last_byte <= {shift, data_bit};
				last_slot <= data_cnt[9:3];
			end
		end
	end

	// ------------------------------------------------------------------------
	// Status and pins
	// ------------------------------------------------------------------------
	assign rif.status = {5'h00, 3'(mode), 4'h0, frame_cnt, 1'b0, last_slot, last_byte};

	assign tx_serial_clock_out    = gen_clk;
	assign tx_serial_clock_oe     = sclk_drive;
	assign tx_frame_sync_out      = fsync_out;
	assign tx_frame_sync_oe       = sync_drive;
	assign tx_multiframe_sync_out = msync_out;
	assign tx_multiframe_sync_oe  = sync_drive && base_mode;

endmodule

/* tb/txrs_top_chk.sv */
`timescale 1ns/1ps
`include "txrs_consts.svh"

module txrs_top_chk (
	input wire logic        ref_clk,
	input wire logic        reset,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        tx_serial_clock_oe,
	input wire logic        tx_multiframe_sync_oe,
	input wire logic        tx_frame_sync_oe
);
	// ------------------------------------------------------------------
	// Shadow of the control registers, rebuilt from bus write phases
	// ------------------------------------------------------------------
	logic        wr_ph;
	logic [11:0] wr_addr;
	logic [3:0]  ctrl;
	logic [1:0]  cfg;
	wire         taken    = hsel && hready && htrans[1];
	wire         hs_mode  = ctrl[1:0] != 2'h0;
	wire  [2:0]  exp_mode = ctrl[2] ? 3'h4 : {1'b0, ctrl[1:0]};
	wire         any_oe   = tx_serial_clock_oe || tx_multiframe_sync_oe || tx_frame_sync_oe;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wr_ph <= 1'h0;
			ctrl  <= 4'h0;
			cfg   <= 2'h0;
		end else begin
			wr_ph   <= taken && hwrite && hsize == 3'h2;
			wr_addr <= haddr[11:0];
			if (wr_ph && wr_addr == `TXRS_ADDR_CTRL) ctrl <= hwdata[3:0];
			if (wr_ph && wr_addr == `TXRS_ADDR_CFG) cfg <= hwdata[1:0];
		end
	end

	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence s_read(logic [11:0] a);
		taken && !hwrite && haddr[11:0] == a;
	endsequence

	// Outputs may lag the register by a cycle, so the five pin-direction checks wait for a settled shadow.
	a_hs_clk_input:  assert property (hs_mode && $stable(ctrl) |-> !tx_serial_clock_oe)
		else $error("serial clock driven in high-speed mode");
	a_base_clk_drive: assert property (!hs_mode && !ctrl[2] && $stable({ctrl, cfg})
		|-> tx_serial_clock_oe == cfg[0]) else $error("base-rate clock direction wrong");
	a_msync_input:   assert property (hs_mode && $stable(ctrl) |-> !tx_multiframe_sync_oe)
		else $error("multiframe pin driven while it is a data clock");
	a_fsync_drive:   assert property (!ctrl[2] && $stable({ctrl, cfg}) |-> tx_frame_sync_oe == cfg[1])
		else $error("frame sync direction wrong");
	a_mux_quiet:     assert property (ctrl[2] && $stable(ctrl) |-> !any_oe)
		else $error("pin driven in multiplexed mode");
	a_mode_status:   assert property (s_read(`TXRS_ADDR_STAT) |=> hrdata[26:24] == exp_mode)
		else $error("status mode field wrong");
	a_ctrl_read:     assert property (s_read(`TXRS_ADDR_CTRL) |=> hrdata == {28'h000_0000, ctrl})
		else $error("control readback wrong");
	a_reset_start:   assert property ($fell(reset) |-> !any_oe && hrdata == 32'h0000_0000)
		else $error("outputs not idle after reset");
endmodule

bind txrs_top txrs_top_chk chk (.ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
	.hready, .hrdata, .tx_serial_clock_oe, .tx_multiframe_sync_oe, .tx_frame_sync_oe);

/* tb/txrs_backplane.sv */
`timescale 1ns/1ps

module txrs_backplane (
	input  logic clk,
	output logic sclk,
	output logic msync,
	output logic fsync,
	output logic sdata
);
	initial begin
		sclk  = 1'b0;
		msync = 1'b0;
		fsync = 1'b0;
		sdata = 1'b0;
	end

	// ------------------------------------------------------------------
	// One frame start and one byte, MSB first, clocks still outside it
	// ------------------------------------------------------------------
	// Pins move right after a clk edge; one link period is 8 clk cycles.
	task automatic send(input logic [7:0] b, input logic hs);
		integer i;
		@(posedge clk);
		fsync <= 1'b1;
		repeat (4) @(posedge clk);
		for (i = 0; i < 8; i++) begin
			sdata <= b[7 - i];
			repeat (2) @(posedge clk);
			sclk  <= 1'b1;
			msync <= hs;
			repeat (4) @(posedge clk);
			sclk  <= 1'b0;
			msync <= 1'b0;
			fsync <= 1'b0;
			repeat (2) @(posedge clk);
		end
		// A released data line must not look like a held last bit.
		sdata <= ~b[0];
	endtask
endmodule

/* tb/tx_backplane_rate_select_bench.sv */
`timescale 1ns/1ps
`include "txrs_consts.svh"

module tx_backplane_rate_select_bench;
	logic        ref_clk, reset, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        sclk_oe, msync_oe, fsync_oe, sclk, msync, fsync, sdata;
	logic        sclk_out, msync_out, fsync_out;
	integer      mismatches, checks, cycles;

	assign hready = hreadyout;

	txrs_top uut (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .tx_serial_clock_in(sclk), .tx_serial_clock_out(sclk_out),
		.tx_serial_clock_oe(sclk_oe), .tx_multiframe_sync_in(msync), .tx_multiframe_sync_out(msync_out),
		.tx_multiframe_sync_oe(msync_oe), .tx_frame_sync_in(fsync), .tx_frame_sync_out(fsync_out),
		.tx_frame_sync_oe(fsync_oe), .tx_serial_data(sdata));

	txrs_backplane bp (.clk(ref_clk), .sclk(sclk), .msync(msync), .fsync(fsync), .sdata(sdata));

	always #10 ref_clk = ~ref_clk;

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			end_of_test();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		hsize  <= 3'h2;
		haddr  <= {20'h0_0000, a};
		do @(posedge ref_clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset();
		ahb(1'b0, `TXRS_ADDR_CTRL, 32'h0000_0000);
		chk("ctrl after reset", rd, 32'h0000_0000);
		chk("hresp", {31'h0000_0000, hresp}, 32'h0000_0000);
		ahb(1'b0, `TXRS_ADDR_STAT, 32'h0000_0000);
		chk("mode after reset", {29'h0000_0000, rd[26:24]}, 32'h0000_0000);
		ahb(1'b0, 12'h00C, 32'h0000_0000);
		chk("unmapped read", rd, 32'h0000_0000);
	endtask

	task automatic t_modes();
		int k;
		ahb(1'b1, `TXRS_ADDR_CFG, 32'h0000_0003);
		for (k = 0; k < 4; k++) begin
			ahb(1'b1, `TXRS_ADDR_CTRL, k);
			ahb(1'b0, `TXRS_ADDR_STAT, 32'h0000_0000);
			chk("mode field", {29'h0000_0000, rd[26:24]}, k);
			chk("clock oe", {31'h0000_0000, sclk_oe}, k == 0);
			chk("msync oe", {31'h0000_0000, msync_oe}, k == 0);
			chk("fsync oe", {31'h0000_0000, fsync_oe}, 32'h0000_0001);
		end
		ahb(1'b1, `TXRS_ADDR_CTRL, 32'h0000_0007);
		ahb(1'b0, `TXRS_ADDR_STAT, 32'h0000_0000);
		chk("mux mode", {29'h0000_0000, rd[26:24]}, txrs_pkg::TXRS_MODE_MUX);
		chk("mux oe", {29'h0000_0000, sclk_oe, msync_oe, fsync_oe}, 32'h0000_0000);
		ahb(1'b1, `TXRS_ADDR_CFG, 32'h0000_0000);
	endtask

	task automatic t_capture(input logic [1:0] code, input logic [7:0] b);
		ahb(1'b1, `TXRS_ADDR_CTRL, {30'h0000_0000, code});
		bp.send(b, code != 2'h0);
		repeat (10) @(posedge ref_clk);
		ahb(1'b0, `TXRS_ADDR_STAT, 32'h0000_0000);
		chk("captured byte", {24'h00_0000, rd[7:0]}, b);
		chk("byte index", {25'h000_0000, rd[14:8]}, 32'h0000_0000);
	endtask

	// The device drives clock and syncs at base rate; periods are counted in ref_clk cycles.
	task automatic t_gen_sync();
		int         n;
		int         k0;
		logic [3:0] f0;
		k0 = `TXRS_REF_KHZ / `TXRS_BASE_KHZ;
		ahb(1'b1, `TXRS_ADDR_CFG, 32'h0000_0003);
		ahb(1'b1, `TXRS_ADDR_CTRL, 32'h0000_0000);
		@(posedge sclk_out);
		n = cycles;
		@(posedge sclk_out);
		chk("clock period", {31'h0000_0000, (cycles - n >= k0) && (cycles - n <= k0 + 1)}, 32'h0000_0001);
		@(posedge fsync_out);
		n = cycles;
		ahb(1'b0, `TXRS_ADDR_STAT, 32'h0000_0000);
		f0 = rd[19:16];
		@(posedge fsync_out);
		chk("frame period", cycles - n, `TXRS_FRAME_US * `TXRS_REF_KHZ / 1000);
		ahb(1'b0, `TXRS_ADDR_STAT, 32'h0000_0000);
		chk("frame step", {28'h000_0000, rd[19:16] - f0}, 32'h0000_0001);
		chk("mframe pulse", {31'h0000_0000, msync_out}, rd[19:16] == 4'h0);
	endtask

	initial begin
		ref_clk    = 1'b0;
		reset      = 1'b1;
		hsel       = 1'b0;
		haddr      = 32'h0000_0000;
		htrans     = 2'h0;
		hwrite     = 1'b0;
		hsize      = 3'h2;
		hwdata     = 32'h0000_0000;
		mismatches = 0;
		checks     = 0;
		cycles     = 0;
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		t_reset();
		t_modes();
		t_capture(`TXRS_RATE_BASE, 8'hA5);
		t_capture(`TXRS_RATE_MVIP, 8'h3C);
		t_capture(`TXRS_RATE_HS4, 8'hC1);
		t_capture(`TXRS_RATE_HS8, 8'h5E);
		t_gen_sync();
		end_of_test();
	end
endmodule
